/* ldpw_dev.sv */
`timescale 1ns/10ps
`default_nettype none
`include "ldpw_map.svh"
module ldpw_dev (
   input wire logic clock,
   input wire logic resetn,
   ldpw_if.dev link,
   input wire logic enable,
   input wire logic undervoltage_lockout,
   input wire logic over_voltage,
   input wire logic over_voltage_clear,
   output logic [4:0] brightness,
   output logic load_pulse,
   output logic power_down,
   output logic switch_node_en
);
   typedef struct packed {
      logic [1:0] ls;
      logic [1:0] es;
      logic [1:0] us;
      logic [1:0] os;
      logic [1:0] cs;
      logic low;
      ldpw_pkg::ldpw_cnt_t cnt;
      ldpw_pkg::ldpw_cnt_t hcnt;
      logic high_ok;
      ldpw_pkg::ldpw_code_t sh;
      ldpw_pkg::ldpw_code_t code;
      logic ld;
      logic ovp;
   } ldpw_dev_s;
   ldpw_dev_s s_r, s_nxt;
   // classify a finished low pulse; widths between windows fall to none
   function automatic ldpw_pkg::ldpw_sym_e classify(input ldpw_pkg::ldpw_cnt_t w);
      if (w >= 16'(`LDPW_LOAD_MIN_CYC)) classify = ldpw_pkg::LDPW_LOAD; // RULE4
      else if (w >= 16'(`LDPW_ZERO_MIN_CYC) && w <= 16'(`LDPW_ZERO_MAX_CYC))
         classify = ldpw_pkg::LDPW_ZERO; // RULE3
      else if (w >= 16'(`LDPW_ONE_MIN_CYC) && w <= 16'(`LDPW_ONE_MAX_CYC))
         classify = ldpw_pkg::LDPW_ONE; // RULE2
      else classify = ldpw_pkg::LDPW_NONE; // RULE12
   endfunction
   logic active;
   ldpw_pkg::ldpw_sym_e sym;
   always_comb begin
      s_nxt = s_r;
      sym = ldpw_pkg::LDPW_NONE;
      s_nxt.ls = {s_r.ls[0], link.line_in};
      s_nxt.es = {s_r.es[0], enable};
      s_nxt.us = {s_r.us[0], undervoltage_lockout};
      s_nxt.os = {s_r.os[0], over_voltage};
      s_nxt.cs = {s_r.cs[0], over_voltage_clear};
      s_nxt.ld = 1'b0;
      active = s_r.es[1] && !s_r.us[1]; // RULE9
      if (!active) begin
         s_nxt.sh = `LDPW_CODE_RST; // RULE7
         s_nxt.code = `LDPW_CODE_RST; // RULE7
         s_nxt.low = 1'b0;
         s_nxt.cnt = '0;
         s_nxt.hcnt = '0;
         s_nxt.high_ok = 1'b0;
      end else if (!s_r.ls[1]) begin
         s_nxt.low = 1'b1;
         // saturate so very long lows still read as a load
         if (s_r.cnt != 16'hffff) s_nxt.cnt = s_r.cnt + 16'h0001;
         s_nxt.hcnt = '0;
      end else begin
         if (s_r.low) begin
            // a pulse not preceded by a valid high time is discarded
            if (s_r.high_ok) sym = classify(s_r.cnt);
            case (sym)
               ldpw_pkg::LDPW_ONE: s_nxt.sh = {s_r.sh[3:0], 1'b1}; // RULE13 RULE2
               ldpw_pkg::LDPW_ZERO: s_nxt.sh = {s_r.sh[3:0], 1'b0}; // RULE13 RULE3
               ldpw_pkg::LDPW_LOAD: begin
                  s_nxt.code = s_r.sh; // RULE4 RULE6
                  s_nxt.ld = 1'b1;
               end
               default: ; // RULE12
            endcase
            s_nxt.high_ok = 1'b0;
         end
         s_nxt.low = 1'b0;
         s_nxt.cnt = '0;
         if (s_r.hcnt != 16'hffff) s_nxt.hcnt = s_r.hcnt + 16'h0001;
         if (s_r.hcnt >= 16'(`LDPW_HIGH_MIN_CYC - 1)) s_nxt.high_ok = 1'b1; // RULE5
      end
      // hysteresis: trip sets, falling below 7 percent clears; no shutdown
      if (s_r.os[1]) s_nxt.ovp = 1'b1; // RULE11
      else if (s_r.cs[1]) s_nxt.ovp = 1'b0; // RULE11
   end
   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         s_r <= '0; // RULE8
      end else begin
         s_r <= s_nxt;
      end
   end
   assign brightness = s_r.code; // RULE6
   assign load_pulse = s_r.ld;
   assign power_down = !(s_r.es[1] && !s_r.us[1]); // RULE9
   assign switch_node_en = !power_down && !s_r.ovp; // RULE11
endmodule // ldpw_dev
`default_nettype wire

/* ldpw_host.sv */
`timescale 1ns/10ps
`default_nettype none
`include "ldpw_map.svh"
module ldpw_host (
   input wire logic clock,
   input wire logic resetn,
   ldpw_if.host link,
   input wire logic send,
   input wire logic [4:0] code,
   output logic ready
);
   typedef struct packed {
      ldpw_pkg::ldpw_tx_e st;
      ldpw_pkg::ldpw_cnt_t cnt;
      logic [4:0] sh;
      logic [2:0] left;
   } ldpw_host_s;
   ldpw_host_s s_r, s_nxt;
   localparam ldpw_pkg::ldpw_cnt_t ONE_C = 16'(`LDPW_TX_ONE_US * `LDPW_CLK_MHZ);
   localparam ldpw_pkg::ldpw_cnt_t ZERO_C = 16'(`LDPW_TX_ZERO_US * `LDPW_CLK_MHZ);
   localparam ldpw_pkg::ldpw_cnt_t LOAD_C = 16'(`LDPW_TX_LOAD_US * `LDPW_CLK_MHZ);
   localparam ldpw_pkg::ldpw_cnt_t HIGH_C = 16'(`LDPW_TX_HIGH_US * `LDPW_CLK_MHZ);
   always_comb begin
      s_nxt = s_r;
      case (s_r.st)
         ldpw_pkg::LDPW_IDLE: begin
            if (send) begin
               s_nxt.sh = code;
               s_nxt.left = 3'h5;
               s_nxt.cnt = code[4] ? ONE_C : ZERO_C; // RULE13 RULE2 RULE3
               s_nxt.st = ldpw_pkg::LDPW_LOW;
            end
         end
         ldpw_pkg::LDPW_LOW: begin
            if (s_r.cnt > 16'h0001) begin
               s_nxt.cnt = s_r.cnt - 16'h0001;
            end else begin
               s_nxt.cnt = HIGH_C; // RULE5
               s_nxt.st = ldpw_pkg::LDPW_HIGH;
            end
         end
         ldpw_pkg::LDPW_HIGH: begin
            if (s_r.cnt > 16'h0001) begin
               s_nxt.cnt = s_r.cnt - 16'h0001;
            end else if (s_r.left == 3'h0) begin
               s_nxt.st = ldpw_pkg::LDPW_IDLE;
            end else begin
               s_nxt.left = s_r.left - 3'h1;
               s_nxt.sh = {s_r.sh[3:0], 1'b0};
               // after the fifth bit the load pulse ends the code
               if (s_r.left == 3'h1) begin
                  s_nxt.cnt = LOAD_C; // RULE4
               end else begin
                  s_nxt.cnt = s_r.sh[3] ? ONE_C : ZERO_C; // RULE13
               end
               s_nxt.st = ldpw_pkg::LDPW_LOW;
            end
         end
         default: s_nxt.st = ldpw_pkg::LDPW_IDLE;
      endcase
   end
   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         s_r <= '{ldpw_pkg::LDPW_IDLE, 16'h0000, 5'h00, 3'h0};
      end else begin
         s_r <= s_nxt;
      end
   end
   // open drain: only ever drive low, release otherwise
   assign link.host_line_o = 1'b0; // RULE1
   assign link.host_line_oe = (s_r.st == ldpw_pkg::LDPW_LOW); // RULE1
   assign ready = (s_r.st == ldpw_pkg::LDPW_IDLE);
endmodule // ldpw_host
`default_nettype wire

/* ldpw_if.sv */
`timescale 1ns/10ps
`default_nettype none
interface ldpw_if;
   logic host_line_o;
   logic host_line_oe;
   logic line_in;
   modport dev (input line_in);
   modport host (output host_line_o, output host_line_oe, input line_in);
endinterface
`default_nettype wire

/* ldpw_map.svh */
// Overview of operation
// RULE1: line idles high, host only pulls low
// RULE2: low 15 to 45 us shifts a one
// RULE3: low 90 to 120 us shifts a zero
// RULE4: low over 215 us loads last five bits
// RULE5: host keeps line high at least 3 us
// RULE6: five-bit code, 32 linear levels
// RULE7: disable or lockout clears shifter and code
// RULE8: code is zero after power-up
// RULE9: enable high runs, low powers down
// RULE10: host resends code after re-enable; ldpw_host has no enable input and sends only when send is raised
// RULE11: overvoltage stops switching, resumes, never shuts down
// RULE12: out-of-range pulse width is ignored
// RULE13: bits travel most significant first
`ifndef LDPW_MAP_SVH
`define LDPW_MAP_SVH
`define LDPW_CLK_MHZ 100
`define LDPW_ONE_MIN_US 15
`define LDPW_ONE_MAX_US 45
`define LDPW_ZERO_MIN_US 90
`define LDPW_ZERO_MAX_US 120
`define LDPW_LOAD_MIN_US 215
`define LDPW_HIGH_MIN_US 3
`define LDPW_ONE_MIN_CYC (`LDPW_ONE_MIN_US * `LDPW_CLK_MHZ)
`define LDPW_ONE_MAX_CYC (`LDPW_ONE_MAX_US * `LDPW_CLK_MHZ)
`define LDPW_ZERO_MIN_CYC (`LDPW_ZERO_MIN_US * `LDPW_CLK_MHZ)
`define LDPW_ZERO_MAX_CYC (`LDPW_ZERO_MAX_US * `LDPW_CLK_MHZ)
`define LDPW_LOAD_MIN_CYC (`LDPW_LOAD_MIN_US * `LDPW_CLK_MHZ)
`define LDPW_HIGH_MIN_CYC (`LDPW_HIGH_MIN_US * `LDPW_CLK_MHZ)
// host aims at the middle of the one and zero windows, and well past the load and high minimums
`define LDPW_TX_ONE_US 30
`define LDPW_TX_ZERO_US 105
`define LDPW_TX_LOAD_US 300
`define LDPW_TX_HIGH_US 10
`define LDPW_CODE_W 5
`define LDPW_CODE_RST 5'h00
`define LDPW_CNT_W 16
`endif

/* ldpw_monitor.sv */
`timescale 1ns/10ps
`default_nettype none
module ldpw_monitor (
   input wire logic clock,
   input wire logic resetn,
   input wire logic host_line_o,
   input wire logic host_line_oe,
   input wire logic enable,
   input wire logic undervoltage_lockout,
   input wire logic over_voltage,
   input wire logic [4:0] brightness,
   input wire logic load_pulse,
   input wire logic switch_node_en
);
   logic [15:0] lo_r, hi_r;
   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) {lo_r, hi_r} <= 32'h0;
      else if (host_line_oe) {lo_r, hi_r} <= {lo_r + 16'h1, 16'h0};
      else {lo_r, hi_r} <= {16'h0, hi_r + {15'h0, ~&hi_r}};
   end
   default clocking @(posedge clock); endclocking
   default disable iff (!resetn);
   sequence s_load; $fell(host_line_oe) ##0 lo_r >= 16'h53fc; endsequence
   a_drive_low: assert property (host_line_oe |-> !host_line_o) else $error("drive");
   a_pulse_width: assert property ($fell(host_line_oe) |-> lo_r inside
      {[16'h05dc:16'h1194], [16'h2328:16'h2ee0], [16'h53fc:16'hffff]}) else $error("width");
   a_high_gap: assert property ($rose(host_line_oe) |-> hi_r >= 16'h012c) else $error("gap");
   a_load_code: assert property (s_load |-> ##[1:6] load_pulse) else $error("load");
   a_off_clears: assert property (!enable[*5] |-> brightness == 5'h0) else $error("off");
   a_lockout_zero: assert property (undervoltage_lockout[*5] |-> brightness == 5'h0)
      else $error("lockout");
   a_ovp_stops: assert property (over_voltage[*5] |-> !switch_node_en) else $error("ovp");
   a_reset_zero: assert property ($rose(resetn) |-> brightness == 5'h0) else $error("reset");
endmodule // ldpw_monitor
`default_nettype wire

/* ldpw_pkg.sv */
package ldpw_pkg;
   typedef logic [4:0] ldpw_code_t;
   typedef logic [15:0] ldpw_cnt_t;
   typedef enum logic [1:0] {LDPW_NONE, LDPW_ONE, LDPW_ZERO, LDPW_LOAD} ldpw_sym_e;
   typedef enum logic [1:0] {LDPW_IDLE, LDPW_LOW, LDPW_HIGH} ldpw_tx_e;
endpackage

/* test_led_dimming_pulse_width_interface.sv */
`timescale 1ns/10ps
`default_nettype none
module test_led_dimming_pulse_width_interface;
   logic clock = 1'h0, resetn = 1'h0, send = 1'h0, enable = 1'h0;
   logic undervoltage_lockout = 1'h0, over_voltage = 1'h0, over_voltage_clear = 1'h0;
   logic [4:0] code = 5'h1d, brightness;
   logic ready, load_pulse, power_down, switch_node_en;
   int errors, checks, cycles;
   ldpw_if link ();
   assign link.line_in = link.host_line_oe ? link.host_line_o : 1'h1;
   ldpw_host ldpw_host_inst (.clock, .resetn, .link(link.host), .send, .code, .ready);
   ldpw_dev ldpw_dev_inst (.clock, .resetn, .link(link.dev), .enable, .undervoltage_lockout,
      .over_voltage, .over_voltage_clear, .brightness, .load_pulse, .power_down, .switch_node_en);
   ldpw_monitor ldpw_monitor_inst (.clock, .resetn, .host_line_o(link.host_line_o),
      .host_line_oe(link.host_line_oe), .enable, .undervoltage_lockout, .over_voltage,
      .brightness, .load_pulse, .switch_node_en);
   always #5 clock = ~clock;
   always @(posedge clock) if (++cycles == 90000) report_and_stop();
   task report_and_stop;
      if (cycles >= 90000) errors++;
      $display("checks %0d errors %0d", checks, errors);
      if (errors == 0 && checks > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask
   task chk(string s, logic [4:0] e, logic [4:0] g);
      checks++;
      if (g !== e) errors++;
      if (g !== e) $display("FAIL %s expected %h seen %h", s, e, g);
   endtask
   task step(int n);
      repeat (n) @(posedge clock);
      #1;
   endtask
   task t_reset;
      step(4);
      resetn = 1'h1;
      enable = 1'h1;
      step(5);
      enable = 1'h0;
      step(5);
      chk("off", 5'h1, {4'h0, power_down});
      // raise enable again so the first code goes out after a re-enable
      enable = 1'h1;
      step(400);
      chk("code", 5'h0, brightness);
      chk("off", 5'h0, {4'h0, power_down});
   endtask
   task t_send;
      send = 1'h1;
      step(1);
      send = 1'h0;
      repeat (60000) if (ready !== 1'h1) step(1);
      step(6);
      chk("code", 5'h1d, brightness);
   endtask
   task t_ovp;
      over_voltage = 1'h1;
      step(5);
      chk("switch", 5'h0, {4'h0, switch_node_en});
      over_voltage = 1'h0;
      over_voltage_clear = 1'h1;
      step(5);
      chk("switch", 5'h1, {4'h0, switch_node_en});
      // trip while the clear input still stands: the trip must win
      over_voltage = 1'h1;
      step(5);
      chk("switch", 5'h0, {4'h0, switch_node_en});
      over_voltage = 1'h0;
      step(5);
      chk("switch", 5'h1, {4'h0, switch_node_en});
      over_voltage_clear = 1'h0;
   endtask
   task t_off;
      undervoltage_lockout = 1'h1;
      step(5);
      chk("code", 5'h0, brightness);
      enable = 1'h0;
      step(5);
      chk("off", 5'h1, {4'h0, power_down});
      // back on: the old level must not return without a new code
      undervoltage_lockout = 1'h0;
      enable = 1'h1;
      step(400);
      chk("off", 5'h0, {4'h0, power_down});
      chk("code", 5'h0, brightness);
   endtask
   initial begin
      t_reset();
      t_send();
      t_ovp();
      t_off();
      report_and_stop();
   end
endmodule // test_led_dimming_pulse_width_interface
`default_nettype wire
